// ==== rtl/dmcp_device.sv ====
module dmcp_device (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // Control link.
  dmcp_if.dev link,
  // Register write notification and mode.
  output logic spi_mode,
  output logic reg_wr_valid,
  output logic [dmcp_pkg::REG_ADDR_W-1:0] reg_wr_addr,
  output logic [dmcp_pkg::BYTE_W-1:0] reg_wr_data
);
  import dmcp_pkg::*;

  // ==========================================================================
  // Helpers

  // Pointer step used by both the write and the read path.
  function automatic logic [REG_ADDR_W-1:0] ptr_next(
    input logic [REG_ADDR_W-1:0] p,
    input logic inc
  );
    ptr_next = inc ? p + 7'h01 : p;
  endfunction

  // Chip address compare for the mode in use.
  function automatic logic addr_hit(
    input logic [BYTE_W-1:0] b,
    input logic spi,
    input logic [1:0] strap
  );
    if (spi) begin
      addr_hit = (b[7:1] == SPI_CHIP_ADDR);
    end else begin
      addr_hit = (b[7:3] == I2C_ADDR_PREFIX) && (b[2:1] == strap);
    end
  endfunction

  // ==========================================================================
  // Declarations
  logic [PIN_COUNT-1:0] pins;
  logic [PIN_COUNT-1:0] s1_ff;
  logic [PIN_COUNT-1:0] s2_ff;
  logic [PIN_COUNT-1:0] s3_ff;
  logic spi_mode_ff;
  logic [1:0] strap_ff;
  dmcp_state_t state_ff;
  dmcp_phase_t phase_ff;
  logic [2:0] cnt_ff;
  logic own_ack_ff;
  logic [6:0] rx_ff;
  logic [BYTE_W-1:0] tx_ff;
  logic [REG_ADDR_W-1:0] ptr_ff;
  logic inc_ff;
  logic [BYTE_W-1:0] regs_ff [REG_COUNT];
  logic wr_valid_ff;
  logic [REG_ADDR_W-1:0] wr_addr_ff;
  logic [BYTE_W-1:0] wr_data_ff;
  logic dout_ff;
  logic doe_ff;
  logic clk_rise;
  logic clk_fall;
  logic sel_fall;
  logic i2c_start;
  logic i2c_stop;
  logic frame_begin;
  logic frame_end;
  logic active;
  logic bit_in;
  logic bit_rise;
  logic byte_end;
  logic tx_shift;
  logic hit;
  logic [BYTE_W-1:0] byte_in;
  logic [REG_ADDR_W-1:0] ptr_adv;

  // ==========================================================================
  // Pin synchronisers

  // Gather the link pins in the order the synchroniser expects.
  always_comb begin
    pins = '0;
    pins[PIN_CLK] = link.ctrl_bit_clock;
    pins[PIN_SEL] = link.addr_strap_or_select_pin;
    pins[PIN_DIN] = link.ctrl_serial_in;
    pins[PIN_STRAP_HI] = link.addr_strap_high;
    pins[PIN_SDA] = link.data_line;
  end

  // Every pin crosses two flops; a third copy only feeds edge detection.
  always_ff @(posedge mclk) begin
    s1_ff <= pins;
    s2_ff <= s1_ff;
    s3_ff <= s2_ff;
  end

  // ==========================================================================
  // Event decode
  always_comb begin
    clk_rise = s2_ff[PIN_CLK] && !s3_ff[PIN_CLK];
    clk_fall = !s2_ff[PIN_CLK] && s3_ff[PIN_CLK];
    sel_fall = s3_ff[PIN_SEL] && !s2_ff[PIN_SEL];
    // Start and stop need the clock high in both sampled copies.
    i2c_start = !spi_mode_ff && s2_ff[PIN_CLK] && s3_ff[PIN_CLK] &&
                s3_ff[PIN_SDA] && !s2_ff[PIN_SDA];
    i2c_stop = !spi_mode_ff && s2_ff[PIN_CLK] && s3_ff[PIN_CLK] &&
               !s3_ff[PIN_SDA] && s2_ff[PIN_SDA];
    frame_begin = sel_fall || i2c_start;
    frame_end = spi_mode_ff ? s2_ff[PIN_SEL] : i2c_stop;
    active = !frame_begin && !frame_end &&
             (state_ff != ST_IDLE) && (state_ff != ST_SKIP);
    bit_in = spi_mode_ff ? s2_ff[PIN_DIN] : s2_ff[PIN_SDA];
    bit_rise = active && (phase_ff == PH_DATA) && clk_rise;
    byte_in = {rx_ff, bit_in};
    byte_end = bit_rise && (cnt_ff == 3'h7);
    hit = addr_hit(byte_in, spi_mode_ff, strap_ff);
    ptr_adv = ptr_next(ptr_ff, inc_ff);
    // Read data moves out on falling edges only, outside acknowledge slots.
    tx_shift = active && (state_ff == ST_RDATA) && clk_fall &&
               ((phase_ff == PH_DATA) || (phase_ff == PH_ACK_DONE));
  end

  // ==========================================================================
  // Mode selection and strap capture

  // The strap is caught by this clocked process while reset is held, so a
  // select pin that later moves cannot disturb the I2C address.
  always_ff @(posedge mclk) begin
    if (reset) begin
      spi_mode_ff <= 1'b0;
      strap_ff <= {s2_ff[PIN_STRAP_HI], s2_ff[PIN_SEL]};
    end else if (sel_fall) begin
      spi_mode_ff <= 1'b1;
    end
  end

  // ==========================================================================
  // Transfer sequencer

  // Walks address, pointer and data bytes and the I2C acknowledge slots.
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      phase_ff <= PH_DATA;
      cnt_ff <= 3'h0;
      own_ack_ff <= 1'b0;
    end else if (frame_begin) begin
      state_ff <= ST_ADDR;
      phase_ff <= PH_DATA;
      cnt_ff <= 3'h0;
    end else if (frame_end) begin
      state_ff <= ST_IDLE;
      phase_ff <= PH_DATA;
      cnt_ff <= 3'h0;
    end else if (active) begin
      case (phase_ff)
        PH_DATA: begin
          if (bit_rise) begin
            cnt_ff <= cnt_ff + 3'h1;
          end
          if (byte_end) begin
            phase_ff <= spi_mode_ff ? PH_DATA : PH_ACK_DRIVE;
            own_ack_ff <= (state_ff != ST_RDATA);
            case (state_ff)
              ST_ADDR: begin
                if (!hit) begin
                  state_ff <= ST_SKIP;
                end else if (byte_in[RW_BIT]) begin
                  state_ff <= ST_RDATA;
                end else begin
                  state_ff <= ST_PTR;
                end
              end
              ST_PTR: begin
                state_ff <= ST_WDATA;
              end
              default: begin
                state_ff <= state_ff;
              end
            endcase
          end
        end
        PH_ACK_DRIVE: begin
          if (clk_fall) begin
            phase_ff <= PH_ACK_CLOCK;
          end
        end
        PH_ACK_CLOCK: begin
          if (clk_rise) begin
            phase_ff <= PH_ACK_DONE;
            // A master that does not acknowledge ends the read burst.
            if ((state_ff == ST_RDATA) && s2_ff[PIN_SDA]) begin
              state_ff <= ST_SKIP;
            end
          end
        end
        default: begin
          if (clk_fall) begin
            phase_ff <= PH_DATA;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Pointer, register array and shift registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      rx_ff <= 7'h00;
      tx_ff <= 8'h00;
      ptr_ff <= 7'h00;
      inc_ff <= 1'b0;
      wr_valid_ff <= 1'b0;
      wr_addr_ff <= 7'h00;
      wr_data_ff <= 8'h00;
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_ff[i] <= REG_RESET;
      end
    end else begin
      wr_valid_ff <= 1'b0;
      if (bit_rise) begin
        rx_ff <= byte_in[6:0];
      end
      if (byte_end) begin
        case (state_ff)
          ST_ADDR: begin
            tx_ff <= regs_ff[ptr_ff];
          end
          ST_PTR: begin
            ptr_ff <= byte_in[REG_ADDR_W-1:0];
            inc_ff <= byte_in[PTR_INC_BIT];
          end
          ST_WDATA: begin
            regs_ff[ptr_ff] <= byte_in;
            wr_valid_ff <= 1'b1;
            wr_addr_ff <= ptr_ff;
            wr_data_ff <= byte_in;
            ptr_ff <= ptr_adv;
          end
          ST_RDATA: begin
            // Next byte is fetched as soon as the last bit has been taken.
            tx_ff <= regs_ff[ptr_adv];
            ptr_ff <= ptr_adv;
          end
          default: begin
            tx_ff <= tx_ff;
          end
        endcase
      end else if (tx_shift) begin
        tx_ff <= {tx_ff[6:0], 1'b0};
      end
    end
  end

  // ==========================================================================
  // Data output driver

  // SPI drives push-pull only during reads; I2C only ever pulls low.
  always_ff @(posedge mclk) begin
    if (reset || (state_ff == ST_IDLE) || (state_ff == ST_SKIP) ||
        frame_end) begin
      doe_ff <= 1'b0;
      dout_ff <= 1'b1;
    end else if (tx_shift) begin
      dout_ff <= spi_mode_ff ? tx_ff[7] : 1'b0;
      doe_ff <= spi_mode_ff || !tx_ff[7];
    end else if (clk_fall && (phase_ff == PH_ACK_DRIVE)) begin
      dout_ff <= 1'b0;
      doe_ff <= own_ack_ff;
    end else if (clk_fall && (phase_ff == PH_ACK_DONE)) begin
      dout_ff <= 1'b1;
      doe_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Outputs
  assign link.ctrl_serial_out = dout_ff;
  assign link.ctrl_serial_out_oe = doe_ff;
  assign spi_mode = spi_mode_ff;
  assign reg_wr_valid = wr_valid_ff;
  assign reg_wr_addr = wr_addr_ff;
  assign reg_wr_data = wr_data_ff;
endmodule

// ==== rtl/dmcp_pkg.sv ====
package dmcp_pkg;
  // ==========================================================================
  // Data and addressing
  localparam int BYTE_W = 8;
  localparam int REG_ADDR_W = 7;
  localparam int REG_COUNT = 128;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [6:0] SPI_CHIP_ADDR = 7'h4F;
  localparam logic [4:0] I2C_ADDR_PREFIX = 5'h13;
  localparam int PTR_INC_BIT = 7;
  localparam int RW_BIT = 0;

  // ==========================================================================
  // Positions of the sampled link pins inside the device synchroniser
  localparam int PIN_CLK = 0;
  localparam int PIN_SEL = 1;
  localparam int PIN_DIN = 2;
  localparam int PIN_STRAP_HI = 3;
  localparam int PIN_SDA = 4;
  localparam int PIN_COUNT = 5;

  // ==========================================================================
  // Timing
  localparam int MCLK_PERIOD_NS = 4;
  localparam int HOST_QTR_NS = 24;
  localparam int HOST_QTR_CYCLES =
    (HOST_QTR_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int HOST_DIV_W = 8;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {OP_WRITE, OP_SET_PTR, OP_READ} dmcp_op_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_RDATA, ST_SKIP
  } dmcp_state_t;
  typedef enum logic [1:0] {
    PH_DATA, PH_ACK_DRIVE, PH_ACK_CLOCK, PH_ACK_DONE
  } dmcp_phase_t;
  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} dmcp_hstate_t;
endpackage

// ==== rtl/dmcp_if.sv ====
interface dmcp_if;
  logic ctrl_bit_clock;
  logic addr_strap_or_select_pin;
  logic addr_strap_high;
  logic ctrl_serial_in;
  logic ctrl_serial_out;
  logic ctrl_serial_out_oe;
  logic host_data_out;
  logic host_data_oe;
  logic data_line;

  // The shared data line is pulled high; any enabled driver may pull it low.
  assign data_line = !(ctrl_serial_out_oe && !ctrl_serial_out) &&
                     !(host_data_oe && !host_data_out);

  modport dev (
    input ctrl_bit_clock,
    input addr_strap_or_select_pin,
    input addr_strap_high,
    input ctrl_serial_in,
    input data_line,
    output ctrl_serial_out,
    output ctrl_serial_out_oe
  );

  modport host (
    output ctrl_bit_clock,
    output addr_strap_or_select_pin,
    output addr_strap_high,
    output ctrl_serial_in,
    output host_data_out,
    output host_data_oe,
    input data_line
  );
endinterface

// ==== rtl/dmcp_host.sv ====
module dmcp_host #(
  parameter int QTR_CYCLES = dmcp_pkg::HOST_QTR_CYCLES
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // Control link.
  dmcp_if.host link,
  // Link configuration.
  input wire logic use_spi,
  input wire logic strap_low,
  input wire logic strap_high,
  // Command.
  input wire logic cmd_valid,
  input wire dmcp_pkg::dmcp_op_t cmd_op,
  input wire logic [dmcp_pkg::BYTE_W-1:0] cmd_ptr,
  input wire logic [dmcp_pkg::BYTE_W-1:0] cmd_data,
  // Status and result.
  output logic busy,
  output logic done,
  output logic nack,
  output logic [dmcp_pkg::BYTE_W-1:0] rd_data
);
  import dmcp_pkg::*;

  // ==========================================================================
  // Declarations
  logic [HOST_DIV_W-1:0] div_ff;
  logic l1_ff;
  logic l2_ff;
  dmcp_hstate_t hst_ff;
  logic [1:0] q_ff;
  logic [3:0] bit_ff;
  logic [1:0] byte_ff;
  logic [BYTE_W-1:0] sh_ff;
  logic [BYTE_W-1:0] rx_ff;
  logic spi_ff;
  logic [1:0] strap_ff;
  dmcp_op_t op_ff;
  logic [BYTE_W-1:0] ptr_ff;
  logic [BYTE_W-1:0] data_ff;
  logic busy_ff;
  logic done_ff;
  logic nack_ff;
  logic [BYTE_W-1:0] rd_ff;
  logic scl_ff;
  logic sel_ff;
  logic sin_ff;
  logic hoe_ff;
  logic shigh_ff;
  logic tick;
  logic rx_byte;
  logic last_byte;
  logic [3:0] last_bit;

  // Byte of the frame at a given position.
  function automatic logic [BYTE_W-1:0] frame_byte(
    input logic [1:0] idx,
    input dmcp_op_t op,
    input logic spi,
    input logic [1:0] strap,
    input logic [BYTE_W-1:0] p,
    input logic [BYTE_W-1:0] d
  );
    logic rd;
    rd = (op == OP_READ);
    if (idx == 2'h0) begin
      frame_byte = spi ? {SPI_CHIP_ADDR, rd} : {I2C_ADDR_PREFIX, strap, rd};
    end else if (idx == 2'h1) begin
      frame_byte = p;
    end else begin
      frame_byte = d;
    end
  endfunction

  // ==========================================================================
  // Quarter-bit divider and data line synchroniser
  always_ff @(posedge mclk) begin
    if (reset || (div_ff == HOST_DIV_W'(QTR_CYCLES - 1))) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    l1_ff <= link.data_line;
    l2_ff <= l1_ff;
  end

  always_comb begin
    tick = (div_ff == HOST_DIV_W'(QTR_CYCLES - 1));
    rx_byte = (op_ff == OP_READ) && (byte_ff == 2'h1);
    last_byte = (byte_ff == ((op_ff == OP_WRITE) ? 2'h2 : 2'h1));
    last_bit = spi_ff ? 4'h7 : 4'h8;
  end

  // ==========================================================================
  // Frame sequencer

  // Each bit takes four quarters: set data, raise clock, sample, lower
  // clock. The host makes the bit clock, so no second domain is needed.
  always_ff @(posedge mclk) begin
    if (reset) begin
      hst_ff <= HS_IDLE;
      q_ff <= 2'h0;
      bit_ff <= 4'h0;
      byte_ff <= 2'h0;
      sh_ff <= 8'h00;
      rx_ff <= 8'h00;
      spi_ff <= use_spi;
      strap_ff <= {strap_high, strap_low};
      op_ff <= OP_WRITE;
      ptr_ff <= 8'h00;
      data_ff <= 8'h00;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      nack_ff <= 1'b0;
      rd_ff <= 8'h00;
      // Idle levels are set in reset so no stray select edge appears.
      scl_ff <= !use_spi;
      sel_ff <= use_spi ? 1'b1 : strap_low;
      sin_ff <= 1'b0;
      hoe_ff <= 1'b0;
      shigh_ff <= strap_high;
    end else begin
      done_ff <= 1'b0;
      case (hst_ff)
        HS_IDLE: begin
          sel_ff <= use_spi ? 1'b1 : strap_low;
          scl_ff <= !use_spi;
          shigh_ff <= strap_high;
          spi_ff <= use_spi;
          strap_ff <= {strap_high, strap_low};
          if (cmd_valid) begin
            op_ff <= cmd_op;
            ptr_ff <= cmd_ptr;
            data_ff <= cmd_data;
            sh_ff <= frame_byte(2'h0, cmd_op, use_spi,
                                {strap_high, strap_low}, cmd_ptr, cmd_data);
            bit_ff <= 4'h0;
            byte_ff <= 2'h0;
            q_ff <= 2'h0;
            nack_ff <= 1'b0;
            busy_ff <= 1'b1;
            hst_ff <= HS_START;
          end
        end
        HS_START: begin
          if (tick) begin
            q_ff <= q_ff + 2'h1;
            if (q_ff == 2'h0) begin
              sel_ff <= spi_ff ? 1'b0 : sel_ff;
            end else if (q_ff == 2'h2) begin
              hoe_ff <= !spi_ff;
            end else if (q_ff == 2'h3) begin
              scl_ff <= 1'b0;
              hst_ff <= HS_BIT;
            end
          end
        end
        HS_BIT: begin
          if (tick) begin
            q_ff <= q_ff + 2'h1;
            case (q_ff)
              2'h0: begin
                if (bit_ff == 4'h8) begin
                  hoe_ff <= rx_byte && !last_byte;
                end else if (rx_byte) begin
                  hoe_ff <= 1'b0;
                end else if (spi_ff) begin
                  sin_ff <= sh_ff[7];
                end else begin
                  hoe_ff <= !sh_ff[7];
                end
              end
              2'h1: begin
                scl_ff <= 1'b1;
              end
              2'h2: begin
                if ((bit_ff != 4'h8) && rx_byte) begin
                  rx_ff <= {rx_ff[6:0], l2_ff};
                end else if ((bit_ff == 4'h8) && !rx_byte && l2_ff) begin
                  nack_ff <= 1'b1;
                end
              end
              default: begin
                scl_ff <= 1'b0;
                if (bit_ff == last_bit) begin
                  bit_ff <= 4'h0;
                  byte_ff <= byte_ff + 2'h1;
                  sh_ff <= frame_byte(byte_ff + 2'h1, op_ff, spi_ff,
                                      strap_ff, ptr_ff, data_ff);
                  if (last_byte || nack_ff) begin
                    hst_ff <= HS_STOP;
                  end
                end else begin
                  bit_ff <= bit_ff + 4'h1;
                  sh_ff <= {sh_ff[6:0], 1'b0};
                end
              end
            endcase
          end
        end
        default: begin
          if (tick) begin
            q_ff <= q_ff + 2'h1;
            if (q_ff == 2'h0) begin
              sel_ff <= spi_ff ? 1'b1 : sel_ff;
              hoe_ff <= !spi_ff;
            end else if (q_ff == 2'h1) begin
              scl_ff <= !spi_ff;
            end else if (q_ff == 2'h2) begin
              hoe_ff <= 1'b0;
            end else begin
              busy_ff <= 1'b0;
              done_ff <= 1'b1;
              rd_ff <= rx_ff;
              hst_ff <= HS_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Outputs
  assign link.ctrl_bit_clock = scl_ff;
  assign link.addr_strap_or_select_pin = sel_ff;
  assign link.addr_strap_high = shigh_ff;
  assign link.ctrl_serial_in = sin_ff;
  assign link.host_data_out = 1'b0;
  assign link.host_data_oe = hoe_ff;
  assign busy = busy_ff;
  assign done = done_ff;
  assign nack = nack_ff;
  assign rd_data = rd_ff;
endmodule

// ==== test/dmcp_monitor.sv ====
module dmcp_monitor (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // Link signals.
  input wire logic ctrl_bit_clock,
  input wire logic addr_strap_or_select_pin,
  input wire logic addr_strap_high,
  input wire logic ctrl_serial_in,
  input wire logic ctrl_serial_out,
  input wire logic ctrl_serial_out_oe,
  input wire logic data_line
);
  timeunit 1ns;
  timeprecision 1ps;
  import dmcp_pkg::*;
  logic spi_ff, clk_q_ff, sel_q_ff, dl_q_ff, rw_ff;
  logic [4:0] cnt_ff;
  logic [2:0] fall_ff;
  logic [7:0] sh_ff;
  logic [1:0] strap_ff;
  logic rise, fall, sel, oe, clr;
  assign sel = addr_strap_or_select_pin;
  assign oe = ctrl_serial_out_oe;
  assign rise = ctrl_bit_clock && !clk_q_ff;
  assign fall = !ctrl_bit_clock && clk_q_ff;
  // A frame restarts on select high in SPI, or on a start in I2C.
  assign clr = spi_ff ? sel : (ctrl_bit_clock && dl_q_ff && !data_line);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  // ==========================================================================
  // Helper logic
  // One-cycle history, so edges need no second synchroniser.
  always_ff @(posedge mclk) begin
    clk_q_ff <= ctrl_bit_clock;
    sel_q_ff <= sel;
    dl_q_ff <= data_line;
  end
  // The I2C straps count only as they stood during reset; later moves on
  // the strap pins must not change which address is acknowledged.
  always_ff @(posedge mclk) begin
    if (reset) strap_ff <= {addr_strap_high, sel};
  end
  // SPI is remembered once select falls after reset.
  always_ff @(posedge mclk) begin
    if (reset) spi_ff <= 1'h0;
    else if (sel_q_ff && !sel) spi_ff <= 1'h1;
  end
  // Rises counted in the frame; saturates so long frames do not wrap.
  always_ff @(posedge mclk) begin
    if (reset || clr) cnt_ff <= 5'h00;
    else if (rise && cnt_ff != 5'h1F) cnt_ff <= cnt_ff + 5'h01;
  end
  // Bits as the device should sample them.
  always_ff @(posedge mclk) begin
    if (rise) sh_ff <= {sh_ff[6:0], spi_ff ? ctrl_serial_in : data_line};
    if (rise && cnt_ff == 5'h07) rw_ff <= ctrl_serial_in;
  end
  // Cycles since the last falling clock edge.
  always_ff @(posedge mclk) begin
    if (fall) fall_ff <= 3'h0;
    else if (fall_ff != 3'h7) fall_ff <= fall_ff + 3'h1;
  end

  // ==========================================================================
  // Assertions
  rst_quiet_a: assert property (
    $fell(reset) |-> !oe && ctrl_serial_out)
    else $error("Device output not released after reset");
  spi_idle_a: assert property (
    (spi_ff && sel)[*6] |-> !oe)
    else $error("Device drives while not selected");
  spi_addr_a: assert property (
    spi_ff && !sel && cnt_ff < 5'h08 |-> !oe)
    else $error("Device drives during the address byte");
  spi_write_a: assert property (
    spi_ff && !sel && cnt_ff >= 5'h08 && !rw_ff |-> !oe)
    else $error("Device drives during a write");
  spi_read_a: assert property (
    spi_ff && !sel && cnt_ff == 5'h08 && rw_ff && fall |-> ##[1:6] oe)
    else $error("Device did not start a read");
  spi_fall_a: assert property (
    spi_ff && oe && $changed(ctrl_serial_out) |-> fall_ff < 3'h7)
    else $error("Output changed away from a falling edge");
  i2c_low_a: assert property (
    !spi_ff && $changed(oe) |-> !ctrl_bit_clock)
    else $error("Device moved the data line with clock high");
  i2c_drain_a: assert property (
    !spi_ff && oe |-> !ctrl_serial_out)
    else $error("Device drove the data line high");
  i2c_ack_a: assert property (
    !spi_ff && rise && cnt_ff == 5'h08 &&
    sh_ff[7:1] == {I2C_ADDR_PREFIX, strap_ff} |-> !data_line)
    else $error("Matching address not acknowledged");
  i2c_nomatch_a: assert property (
    !spi_ff && rise && cnt_ff == 5'h08 &&
    sh_ff[7:1] != {I2C_ADDR_PREFIX, strap_ff} |-> !oe)
    else $error("Other address acknowledged");
  cover property (spi_ff && oe);
  cover property (!spi_ff && rise && cnt_ff == 5'h08);
  cover property (spi_ff && rise && cnt_ff == 5'h17);
endmodule

// ==== test/dmcp_tb_top.sv ====
module dmcp_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dmcp_pkg::*;
  typedef struct {
    logic spi;
    dmcp_op_t op;
    logic [7:0] ptr, dat, exp;
  } dmcp_row_t;
  logic mclk, reset, use_spi, strap_low, strap_high, cmd_valid;
  logic busy, done, nack, spi_mode, reg_wr_valid;
  logic [7:0] cmd_ptr, cmd_data, rd_data, reg_wr_data, wa, wd, wr_cnt;
  logic [6:0] reg_wr_addr;
  dmcp_op_t cmd_op;
  int fails, checks, cyc;
  // Pointer bit 7 asks for auto-increment; reset clears between modes.
  dmcp_row_t rows [15] = '{
    '{1'h1, OP_WRITE, 8'h05, 8'hA5, 8'h00},
    '{1'h1, OP_WRITE, 8'h86, 8'h3C, 8'h00},
    '{1'h1, OP_SET_PTR, 8'h05, 8'h00, 8'h00},
    '{1'h1, OP_READ, 8'h00, 8'h00, 8'hA5},
    '{1'h1, OP_READ, 8'h00, 8'h00, 8'hA5},
    '{1'h1, OP_SET_PTR, 8'h85, 8'h00, 8'h00},
    '{1'h1, OP_READ, 8'h00, 8'h00, 8'hA5},
    '{1'h1, OP_READ, 8'h00, 8'h00, 8'h3C},
    '{1'h0, OP_SET_PTR, 8'h05, 8'h00, 8'h00},
    '{1'h0, OP_READ, 8'h00, 8'h00, 8'h00},
    '{1'h0, OP_WRITE, 8'h90, 8'h77, 8'h00},
    '{1'h0, OP_WRITE, 8'h11, 8'hE1, 8'h00},
    '{1'h0, OP_SET_PTR, 8'h90, 8'h00, 8'h00},
    '{1'h0, OP_READ, 8'h00, 8'h00, 8'h77},
    '{1'h0, OP_READ, 8'h00, 8'h00, 8'hE1}
  };

  dmcp_if dmcp_if_inst ();
  dmcp_host dmcp_host_inst (.mclk(mclk), .reset(reset),
    .link(dmcp_if_inst.host), .use_spi(use_spi), .strap_low(strap_low),
    .strap_high(strap_high), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_ptr(cmd_ptr), .cmd_data(cmd_data), .busy(busy), .done(done),
    .nack(nack), .rd_data(rd_data));
  dmcp_device dmcp_device_inst (.mclk(mclk), .reset(reset),
    .link(dmcp_if_inst.dev), .spi_mode(spi_mode),
    .reg_wr_valid(reg_wr_valid), .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data));
  dmcp_monitor dmcp_monitor_inst (.mclk(mclk), .reset(reset),
    .ctrl_bit_clock(dmcp_if_inst.ctrl_bit_clock),
    .addr_strap_or_select_pin(dmcp_if_inst.addr_strap_or_select_pin),
    .addr_strap_high(dmcp_if_inst.addr_strap_high),
    .ctrl_serial_in(dmcp_if_inst.ctrl_serial_in),
    .ctrl_serial_out(dmcp_if_inst.ctrl_serial_out),
    .ctrl_serial_out_oe(dmcp_if_inst.ctrl_serial_out_oe),
    .data_line(dmcp_if_inst.data_line));

  // ==========================================================================
  // Clock, write capture and hang guard
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  // Writes are caught on the falling edge, clear of flop updates.
  always @(negedge mclk) begin
    if (reg_wr_valid === 1'h1) begin
      wr_cnt = wr_cnt + 8'h01;
      wa = {1'h0, reg_wr_addr};
      wd = reg_wr_data;
    end
  end
  // About 19 frames of under 800 cycles each fit well inside this.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      results();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input string nm, input logic [7:0] e, a);
    checks++;
    if (a !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, a);
    end
  endtask
  task automatic do_reset(input logic spi);
    @(posedge mclk);
    use_spi <= spi;
    reset <= 1'h1;
    repeat (4) @(posedge mclk);
    reset <= 1'h0;
  endtask
  // One command, then a bounded wait for its completion pulse.
  task automatic do_op(input dmcp_row_t r);
    logic [7:0] w0;
    int n;
    w0 = wr_cnt;
    n = 0;
    @(posedge mclk);
    cmd_op <= r.op;
    cmd_ptr <= r.ptr;
    cmd_data <= r.dat;
    cmd_valid <= 1'h1;
    @(posedge mclk);
    cmd_valid <= 1'h0;
    @(negedge mclk);
    chk("busy", 8'h01, {7'h00, busy});
    while (done !== 1'h1 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    chk("done", 8'h01, {7'h00, done});
    chk("busy", 8'h00, {7'h00, busy});
    // Every reset latches straps 0 and 1, so a high strap_high now makes
    // the host call another address, which must go unanswered.
    if (!r.spi) chk("nack", {7'h00, strap_high}, {7'h00, nack});
    chk("spi_mode", {7'h00, r.spi}, {7'h00, spi_mode});
    if (r.op == OP_READ) chk("rd_data", r.exp, rd_data);
    if (r.op == OP_WRITE && !strap_high) begin
      chk("wr_count", w0 + 8'h01, wr_cnt);
      chk("wr_addr", {1'h0, r.ptr[6:0]}, wa);
      chk("wr_data", r.dat, wd);
    end
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    reset = 1'h1;
    use_spi = 1'h1;
    strap_low = 1'h1;
    strap_high = 1'h0;
    cmd_valid = 1'h0;
    cmd_op = OP_WRITE;
    cmd_ptr = 8'h00;
    cmd_data = 8'h00;
    wr_cnt = 8'h00;
    do_reset(1'h1);
    for (int i = 0; i < 15; i++) begin
      if (i > 0 && rows[i].spi !== rows[i-1].spi) do_reset(rows[i].spi);
      do_op(rows[i]);
    end
    // Reset inside the pointer byte: no write may land, registers clear.
    @(posedge mclk);
    cmd_op <= OP_WRITE;
    cmd_ptr <= 8'h10;
    cmd_data <= 8'h55;
    cmd_valid <= 1'h1;
    @(posedge mclk);
    cmd_valid <= 1'h0;
    repeat (300) @(posedge mclk);
    do_reset(1'h0);
    chk("wr_count", 8'h04, wr_cnt);
    // A strap that differs from the latched one: no acknowledge, no write.
    @(posedge mclk);
    strap_high <= 1'h1;
    do_op('{1'h0, OP_WRITE, 8'h10, 8'h66, 8'h00});
    @(posedge mclk);
    strap_high <= 1'h0;
    chk("wr_count", 8'h04, wr_cnt);
    do_op('{1'h0, OP_SET_PTR, 8'h10, 8'h00, 8'h00});
    do_op('{1'h0, OP_READ, 8'h00, 8'h00, 8'h00});
    results();
  end
endmodule
